// ### design/pwm_steer_pkg.sv
/*
  Package for the enhanced PWM output stage: register map, field positions,
  reset values, timing counts, carrier types and shared helper functions.
  Assumes one clock domain and an AHB-Lite register slave with word registers.
*/
// How it works
// - Steering runs only when the mode field's upper two bits are 11 and the output config is 00.
// - In steering, every pin whose steer enable bit is set carries the same waveform.
// - While steering, the low two mode bits set the active polarity of the pins.
// - A shutdown forces only the pins that carry the waveform; other pins stay ordinary port pins.
// - With auto restart set, hardware clears the shutdown status once the event goes away.
// - Each delayed transition waits the seven-bit delay count times four clock periods.
// - Half-bridge config 10 drives A and B complementary, separated by the dead band.
// - Full-bridge forward config 01 holds A active, B and C inactive, and modulates D.
// - Full-bridge reverse config 11 holds C active, A and D inactive, and modulates B.
package pwm_steer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_DEADBAND = 8'h04;
  localparam logic [7:0] OFS_STEER    = 8'h08;
  localparam logic [7:0] OFS_PORT     = 8'h0c;
  localparam logic [7:0] OFS_SD_STAT  = 8'h10;
  localparam logic [7:0] OFS_INT_STS  = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;

  // Reset values
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_DEADBAND = 8'h00;
  localparam logic [3:0] RST_STEER    = 4'h0;
  localparam logic [7:0] RST_PORT     = 8'h0f;
  localparam logic [1:0] RST_INT      = 2'h0;

  // Field positions
  localparam int MODE_SEL_LSB  = 0;
  localparam int CFG_SEL_LSB   = 6;
  localparam int RESTART_BIT   = 7;
  localparam int DIR_LSB       = 0;
  localparam int LATCH_LSB     = 4;
  localparam int EV_SHUTDOWN   = 0;
  localparam int EV_RESTART    = 1;

  // Mode field upper bits that select the enhanced PWM output stage
  localparam logic [1:0] MODE_PWM  = 2'h3;

  // Clock periods per delay count (one instruction cycle)
  localparam int unsigned OSC_PER_COUNT = 4;
  localparam int          DLY_CNT_W     = 9;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_FWD    = 2'h1,
    CFG_HALF   = 2'h2,
    CFG_REV    = 2'h3
  } out_cfg_e;

  // Pin bundle: index 0..3 are outputs A..D
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pins_s;

  function automatic logic [DLY_CNT_W-1:0] delay_cycles(input logic [6:0] count);
    delay_cycles = DLY_CNT_W'({2'h0, count} * OSC_PER_COUNT);
  endfunction

  // Polarity of pins A..D: low mode bit for B,D and bit 1 for A,C
  function automatic logic [3:0] pol_vec(input logic [3:0] mode);
    pol_vec = {mode[0], mode[1], mode[0], mode[1]};
  endfunction

endpackage

// ### design/deadband_delay.sv
/*
  Dead-band delay for one output: the active-going edge is held back by the
  delay count times four clocks, the inactive-going edge passes at once.
  Assumes din and the count are synchronous to hclk.
*/
module deadband_delay
  import pwm_steer_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Waveform
  input  wire logic       din,
  input  wire logic [6:0] dly,
  output      logic       dout
);

  logic [DLY_CNT_W-1:0] cnt_r;
  logic [DLY_CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!din) begin
      cnt_nxt = delay_cycles(dly);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Zero count leaves the counter at zero, so the rise passes the same cycle
  assign dout = din && (cnt_r == '0);

  property p_delay_four;
    @(posedge hclk) disable iff (!hresetn)
    ($rose(din) && dly == 7'd1 && $past(dly) == 7'd1) ##1 din[*4]
      |-> dout && !$past(dout) && !$past(dout, 2) && !$past(dout, 3) && !$past(dout, 4);
  endproperty
  a_delay_four: assert property (p_delay_four) else $error("dead band not four clocks");

  property p_zero_delay;
    @(posedge hclk) disable iff (!hresetn)
    (dly == 7'd0 && $past(dly) == 7'd0 && $past(din) == 1'b0) |-> (dout == din);
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero count delayed edge");

endmodule // deadband_delay

// ### design/enhanced_pwm_steering_deadband.sv
/*
  Enhanced PWM output stage: maps one PWM waveform onto pins A..D in single
  (steered), half-bridge or full-bridge form, with dead band, polarity,
  auto-shutdown and restart, an AHB-Lite register slave and one interrupt.
  Assumes pwm_wave and shutdown_evt come from logic on hclk, and a single
  AHB-Lite master with whole-word single transfers.
*/
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
module enhanced_pwm_steering_deadband
  import pwm_steer_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // Waveform and shutdown from the timer side
  input  wire logic        pwm_wave,
  input  wire logic        shutdown_evt,
  // Output pins and interrupt
  output      pins_s       pins,
  output      logic        irq
);

  // Bus data phase state
  logic        dp_valid_r;
  logic        dp_valid_nxt;
  logic        dp_write_r;
  logic        dp_write_nxt;
  logic [7:0]  dp_addr_r;
  logic [7:0]  dp_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        hreadyout_r;

  // Software registers
  logic [7:0]  mode_r;
  logic [7:0]  mode_nxt;
  logic [7:0]  pwm_deadband_ctrl_r;
  logic [7:0]  pwm_deadband_ctrl_nxt;
  logic [3:0]  steer_enable_bits_r;
  logic [3:0]  steer_enable_bits_nxt;
  logic [7:0]  port_r;
  logic [7:0]  port_nxt;

  // Shutdown and interrupt state
  logic        shutdown_event_status_r;
  logic        shutdown_event_status_nxt;
  logic [1:0]  int_sts_r;
  logic [1:0]  int_sts_nxt;
  logic [1:0]  int_mask_r;
  logic [1:0]  int_mask_nxt;
  logic        irq_r;
  logic        irq_nxt;

  // Pin state
  pins_s       pins_r;
  pins_s       pins_nxt;

  // Decoded fields
  logic [3:0]  ccp_mode_sel;
  out_cfg_e    output_config_sel;
  logic        auto_restart_en;
  logic [6:0]  deadband_delay_count;
  logic [3:0]  pin_direction;
  logic [3:0]  port_latch;
  logic        pwm_active;
  logic        sd_set;
  logic        wr_en;
  logic        rd_take;
  logic [3:0]  own;
  logic [3:0]  lvl;
  logic [3:0]  pol;
  logic        dly_a;
  logic        dly_b;

  assign ccp_mode_sel         = mode_r[MODE_SEL_LSB +: 4];
  assign output_config_sel    = out_cfg_e'(mode_r[CFG_SEL_LSB +: 2]);
  assign auto_restart_en      = pwm_deadband_ctrl_r[RESTART_BIT];
  assign deadband_delay_count = pwm_deadband_ctrl_r[6:0];
  assign pin_direction        = port_r[DIR_LSB +: 4];
  assign port_latch           = port_r[LATCH_LSB +: 4];
  assign pwm_active           = (ccp_mode_sel[3:2] == MODE_PWM);
  assign pol                  = pol_vec(ccp_mode_sel);
  assign sd_set               = pwm_active && shutdown_evt;
  assign wr_en                = dp_valid_r && dp_write_r;
  assign rd_take              = hsel && hready && htrans[1];

  // Dead band on the active-going edge of each half-bridge leg
  deadband_delay u_dly_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pwm_wave),
    .dly     (deadband_delay_count),
    .dout    (dly_a)
  );

  deadband_delay u_dly_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (!pwm_wave),
    .dly     (deadband_delay_count),
    .dout    (dly_b)
  );

  // Bus slave: zero wait states, read data registered at the address phase
  always_comb begin
    dp_valid_nxt = rd_take;
    dp_write_nxt = hwrite;
    dp_addr_nxt  = haddr[7:0];
    hrdata_nxt   = hrdata_r;
    if (rd_take && !hwrite) begin
      if (haddr[7:0] == OFS_MODE) begin
        hrdata_nxt = {24'h0, mode_r};
      end else if (haddr[7:0] == OFS_DEADBAND) begin
        hrdata_nxt = {24'h0, pwm_deadband_ctrl_r};
      end else if (haddr[7:0] == OFS_STEER) begin
        hrdata_nxt = {28'h0, steer_enable_bits_r};
      end else if (haddr[7:0] == OFS_PORT) begin
        hrdata_nxt = {24'h0, port_r};
      end else if (haddr[7:0] == OFS_SD_STAT) begin
        hrdata_nxt = {31'h0, shutdown_event_status_r};
      end else if (haddr[7:0] == OFS_INT_STS) begin
        hrdata_nxt = {30'h0, int_sts_r};
      end else if (haddr[7:0] == OFS_INT_MASK) begin
        hrdata_nxt = {30'h0, int_mask_r};
      end else begin
        hrdata_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r  <= 1'b0;
      dp_write_r  <= 1'b0;
      dp_addr_r   <= 8'h0;
      hrdata_r    <= 32'h0;
      hreadyout_r <= 1'b1;
    end else begin
      dp_valid_r  <= dp_valid_nxt;
      dp_write_r  <= dp_write_nxt;
      dp_addr_r   <= dp_addr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
    end
  end

  // Register writes land at the end of the data phase
  always_comb begin
    mode_nxt              = mode_r;
    pwm_deadband_ctrl_nxt = pwm_deadband_ctrl_r;
    steer_enable_bits_nxt = steer_enable_bits_r;
    port_nxt              = port_r;
    int_mask_nxt          = int_mask_r;
    if (wr_en) begin
      if (dp_addr_r == OFS_MODE) begin
        mode_nxt = hwdata[7:0];
      end else if (dp_addr_r == OFS_DEADBAND) begin
        pwm_deadband_ctrl_nxt = hwdata[7:0];
      end else if (dp_addr_r == OFS_STEER) begin
        steer_enable_bits_nxt = hwdata[3:0];
      end else if (dp_addr_r == OFS_PORT) begin
        port_nxt = hwdata[7:0];
      end else if (dp_addr_r == OFS_INT_MASK) begin
        int_mask_nxt = hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r              <= RST_MODE;
      pwm_deadband_ctrl_r <= RST_DEADBAND;
      steer_enable_bits_r <= RST_STEER;
      port_r              <= RST_PORT;
      int_mask_r          <= RST_INT;
    end else begin
      mode_r              <= mode_nxt;
      pwm_deadband_ctrl_r <= pwm_deadband_ctrl_nxt;
      steer_enable_bits_r <= steer_enable_bits_nxt;
      port_r              <= port_nxt;
      int_mask_r          <= int_mask_nxt;
    end
  end

  // Shutdown status and interrupt flags; a new event beats any clear
  always_comb begin
    shutdown_event_status_nxt = shutdown_event_status_r;
    if (auto_restart_en && !shutdown_evt) begin
      shutdown_event_status_nxt = 1'b0;
    end
    if (!auto_restart_en && wr_en && dp_addr_r == OFS_SD_STAT && !hwdata[0]) begin
      shutdown_event_status_nxt = 1'b0;
    end
    if (sd_set) begin
      shutdown_event_status_nxt = 1'b1;
    end
    int_sts_nxt = int_sts_r;
    if (wr_en && dp_addr_r == OFS_INT_STS) begin
      int_sts_nxt = int_sts_r & ~hwdata[1:0];
    end
    if (sd_set && !shutdown_event_status_r) begin
      int_sts_nxt[EV_SHUTDOWN] = 1'b1;
    end
    if (shutdown_event_status_r && !shutdown_event_status_nxt) begin
      int_sts_nxt[EV_RESTART] = 1'b1;
    end
    irq_nxt = |(int_sts_nxt & int_mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_event_status_r <= 1'b0;
      int_sts_r               <= RST_INT;
      irq_r                   <= 1'b0;
    end else begin
      shutdown_event_status_r <= shutdown_event_status_nxt;
      int_sts_r               <= int_sts_nxt;
      irq_r                   <= irq_nxt;
    end
  end

  // Pin steering; index 0..3 are pins A..D
  always_comb begin
    own = 4'h0;
    lvl = 4'h0;
    case (output_config_sel)
      CFG_SINGLE: begin
        own = steer_enable_bits_r;
        lvl = {4{pwm_wave}};
      end
      CFG_HALF: begin
        own = 4'h3;
        lvl = {2'h0, dly_b, dly_a};
      end
      CFG_FWD: begin
        own = 4'hf;
        lvl = {pwm_wave, 1'b0, 1'b0, 1'b1};
      end
      CFG_REV: begin
        own = 4'hf;
        lvl = {1'b0, 1'b1, pwm_wave, 1'b0};
      end
      default: begin
        own = 4'h0;
        lvl = 4'h0;
      end
    endcase
    if (!pwm_active) begin
      own = 4'h0;
    end
    // Shutdown parks only the pins that carry the waveform
    if (shutdown_event_status_r) begin
      lvl = 4'h0;
    end
    pins_nxt.level = (own & (lvl ^ pol)) | (~own & port_latch);
    // The driver only follows a cleared direction bit
    pins_nxt.oe    = ~pin_direction;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign pins      = pins_r;
  assign irq       = irq_r;

  sequence s_steer_on;
    pwm_active && output_config_sel == CFG_SINGLE;
  endsequence

  sequence s_running;
    !shutdown_event_status_r;
  endsequence

  property p_steer_gate;
    @(posedge hclk) disable iff (!hresetn)
    (!pwm_active) |=> (pins_r.level == $past(port_latch));
  endproperty
  a_steer_gate: assert property (p_steer_gate) else $error("pin driven outside pwm mode");

  property p_steer_copy;
    @(posedge hclk) disable iff (!hresetn)
    (s_steer_on and s_running) |=>
      (pins_r.level == (($past(steer_enable_bits_r) & ({4{$past(pwm_wave)}} ^ $past(pol)))
                       | (~$past(steer_enable_bits_r) & $past(port_latch))));
  endproperty
  a_steer_copy: assert property (p_steer_copy) else $error("steered pins wrong");

  property p_polarity;
    @(posedge hclk) disable iff (!hresetn)
    (s_steer_on and s_running) ##0 (steer_enable_bits_r[1] && ccp_mode_sel[0])
      |=> (pins_r.level[1] == !$past(pwm_wave));
  endproperty
  a_polarity: assert property (p_polarity) else $error("active-low pin B not inverted");

  property p_shut_pins;
    @(posedge hclk) disable iff (!hresetn)
    (pwm_active && shutdown_event_status_r) |=>
      (pins_r.level == (($past(own) & $past(pol)) | (~$past(own) & $past(port_latch))));
  endproperty
  a_shut_pins: assert property (p_shut_pins) else $error("shutdown level wrong");

  property p_restart;
    @(posedge hclk) disable iff (!hresetn)
    (shutdown_event_status_r && auto_restart_en && !shutdown_evt)
      |=> !shutdown_event_status_r && int_sts_r[EV_RESTART];
  endproperty
  a_restart: assert property (p_restart) else $error("auto restart did not clear");

  property p_half;
    @(posedge hclk) disable iff (!hresetn)
    (pwm_active && output_config_sel == CFG_HALF) ##0 s_running
      |=> !((pins_r.level[0] ^ $past(pol[0])) && (pins_r.level[1] ^ $past(pol[1])));
  endproperty
  a_half: assert property (p_half) else $error("half bridge legs overlap");

  property p_fwd;
    @(posedge hclk) disable iff (!hresetn)
    (pwm_active && output_config_sel == CFG_FWD) ##0 s_running
      |=> (pins_r.level == ({$past(pwm_wave), 3'b001} ^ $past(pol)));
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward bridge levels wrong");

  property p_rev;
    @(posedge hclk) disable iff (!hresetn)
    (pwm_active && output_config_sel == CFG_REV) ##0 s_running
      |=> (pins_r.level == ({2'b01, $past(pwm_wave), 1'b0} ^ $past(pol)));
  endproperty
  a_rev: assert property (p_rev) else $error("reverse bridge levels wrong");

endmodule // enhanced_pwm_steering_deadband

// ### tb/bridge_driver_model.sv
/*
  Model of the external bridge drivers on pins A..D.
  Assumes each gate driver input has a pull-down, so a pin the block does not
  drive reads low rather than keeping its last level.
*/
module bridge_driver_model
  import pwm_steer_pkg::*;
(
  // Block pins
  input  wire pins_s       pins,
  // Levels seen by the drivers
  output      logic [3:0]  pad
);
  timeunit 1ns;
  timeprecision 1ps;

  // Undriven pin falls to the pull-down level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad[i] = pins.oe[i] ? pins.level[i] : 1'b0;
    end
  end
endmodule // bridge_driver_model

// ### tb/testbench.sv
/*
  Self-checking bench for the enhanced PWM output stage.
  Assumes the zero-wait AHB-Lite slave and the bridge driver model beside it.
*/
module testbench
  import pwm_steer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk, hresetn, hsel, hwrite, pwm_wave, shutdown_evt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, irq;
  pins_s       pins;
  logic [3:0]  pad;
  int          mismatches, comparisons;

  enhanced_pwm_steering_deadband dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_wave(pwm_wave),
    .shutdown_evt(shutdown_evt), .pins(pins), .irq(irq));

  bridge_driver_model load_u (.pins(pins), .pad(pad));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Samples hready at each rising edge; returns just after the edge that saw it high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask

  // One single word transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    // Read data is taken at the same edge that saw the data phase complete
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Pins answer two edges after a change, so three falling edges is settled
  task automatic pchk(input logic [3:0] exp);
    repeat (3) @(negedge hclk);
    chk({28'h0, pad}, {28'h0, exp});
    @(posedge hclk);
  endtask

  task automatic ichk(input logic exp);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge hclk);
  endtask

  // Cycles until a pin goes active after the wave changes; legs never overlap
  task automatic lat(input logic w, input int pin, output int n);
    pwm_wave <= w;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
      if (pad[0] === 1'b1 && pad[1] === 1'b1) chk({28'h0, pad}, 32'h0);
    end while (pad[pin] !== 1'b1 && n < 600);
    if (pad[pin] !== 1'b1) begin
      mismatches++;
      test_done();
    end
    @(posedge hclk);
  endtask

  task automatic t_reset();
    rchk(OFS_MODE, 32'h0);
    rchk(OFS_DEADBAND, 32'h0);
    rchk(OFS_STEER, 32'h0);
    rchk(OFS_PORT, 32'h0f);
    rchk(OFS_SD_STAT, 32'h0);
    rchk(OFS_INT_STS, 32'h0);
    rchk(OFS_INT_MASK, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rchk(8'h1c, 32'h0);
    bus(1'b1, OFS_DEADBAND, 32'hff);
    rchk(OFS_DEADBAND, 32'hff);
    bus(1'b1, OFS_DEADBAND, 32'h0);
    chk({28'h0, pins.oe}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic t_steer();
    logic [3:0] p;
    bus(1'b1, OFS_PORT, 32'ha0);
    bus(1'b1, OFS_MODE, 32'h0c);
    bus(1'b1, OFS_STEER, 32'h5);
    pwm_wave <= 1'b1;
    pchk(4'hf);
    pwm_wave <= 1'b0;
    pchk(4'ha);
    bus(1'b1, OFS_PORT, 32'h00);
    pwm_wave <= 1'b1;
    for (int s = 1; s < 16; s++) begin
      bus(1'b1, OFS_STEER, 32'(s));
      pchk(4'(s));
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_MODE, 32'h0c | 32'(m));
      p = 4'(m);
      for (int w = 0; w < 2; w++) begin
        pwm_wave <= w[0];
        pchk({w[0] ^ p[0], w[0] ^ p[1], w[0] ^ p[0], w[0] ^ p[1]});
      end
    end
    bus(1'b1, OFS_PORT, 32'h50);
    pwm_wave <= 1'b1;
    for (int u = 0; u < 3; u++) begin
      bus(1'b1, OFS_MODE, 32'(u << 2));
      pchk(4'h5);
    end
    bus(1'b1, OFS_MODE, 32'h0c);
    bus(1'b1, OFS_PORT, 32'h51);
    pchk(4'he);
    bus(1'b1, OFS_PORT, 32'h00);
  endtask

  task automatic t_bridge();
    for (int w = 0; w < 2; w++) begin
      pwm_wave <= w[0];
      bus(1'b1, OFS_MODE, 32'h4c);
      pchk({w[0], 2'b00, 1'b1});
      bus(1'b1, OFS_MODE, 32'hcc);
      pchk({1'b0, 1'b1, w[0], 1'b0});
    end
  endtask

  task automatic t_deadband();
    int d[3] = '{0, 1, 127};
    int r0, f0, r, f, x;
    bus(1'b1, OFS_MODE, 32'h8c);
    foreach (d[k]) begin
      bus(1'b1, OFS_DEADBAND, 32'(d[k]));
      lat(1'b0, 1, x);
      lat(1'b1, 0, r);
      lat(1'b0, 1, f);
      if (k == 0) begin
        r0 = r;
        f0 = f;
        chk(32'(r0 <= 2 && f0 <= 2), 32'h1);
      end else begin
        chk(32'(r - r0), 32'(4 * d[k]));
        chk(32'(f - f0), 32'(4 * d[k]));
      end
    end
    bus(1'b1, OFS_DEADBAND, 32'h0);
  endtask

  task automatic t_shutdown();
    bus(1'b1, OFS_PORT, 32'hc0);
    bus(1'b1, OFS_MODE, 32'h0c);
    bus(1'b1, OFS_STEER, 32'h3);
    bus(1'b1, OFS_INT_MASK, 32'h3);
    pwm_wave <= 1'b1;
    pchk(4'hf);
    shutdown_evt <= 1'b1;
    pchk(4'hc);
    ichk(1'b1);
    rchk(OFS_SD_STAT, 32'h1);
    shutdown_evt <= 1'b0;
    pchk(4'hc);
    rchk(OFS_SD_STAT, 32'h1);
    bus(1'b1, OFS_SD_STAT, 32'h0);
    pchk(4'hf);
    bus(1'b1, OFS_INT_STS, 32'h3);
    rchk(OFS_INT_STS, 32'h0);
    ichk(1'b0);
    bus(1'b1, OFS_DEADBAND, 32'h80);
    shutdown_evt <= 1'b1;
    pchk(4'hc);
    shutdown_evt <= 1'b0;
    pchk(4'hf);
    rchk(OFS_SD_STAT, 32'h0);
    rchk(OFS_INT_STS, 32'h3);
    ichk(1'b1);
    bus(1'b1, OFS_INT_MASK, 32'h0);
    ichk(1'b0);
    bus(1'b1, OFS_INT_MASK, 32'h3);
    bus(1'b1, OFS_INT_STS, 32'h3);
    ichk(1'b0);
    rchk(OFS_INT_STS, 32'h0);
  endtask

  initial begin
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    pwm_wave     = 1'b0;
    shutdown_evt = 1'b0;
    mismatches   = 0;
    comparisons  = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_steer();
    t_bridge();
    t_deadband();
    t_shutdown();
    test_done();
  end
endmodule // testbench
